/* src/tws_map.vh */
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
// Register byte addresses on the AXI4-Lite slave.
`define TWS_ADDR_CTRL 4'h0
`define TWS_ADDR_STAT 4'h4
`define TWS_ADDR_DATA 4'h8
`define TWS_ADDR_SLA 4'hc
`define TWS_AW 4
// Control register bit positions.
`define TWS_C_DONE 7
`define TWS_C_ACK 6
`define TWS_C_STA 5
`define TWS_C_STO 4
`define TWS_C_WCOL 3
`define TWS_C_EN 2
`define TWS_C_SLEEP 1
`define TWS_C_IE 0
// Status codes, prescaler bits always zero.
`define TWS_ST_SLA_R 8'ha8
`define TWS_ST_ARB_R 8'hb0
`define TWS_ST_DACK 8'hb8
`define TWS_ST_DNACK 8'hc0
`define TWS_ST_LAST_ACK 8'hc8
`define TWS_ST_NONE 8'hf8
`define TWS_ST_BUSERR 8'h00
`define TWS_GCALL 7'h00
`define TWS_RESP_OKAY 2'b00
`define TWS_RESP_SLVERR 2'b10
`endif

/* src/tws_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for one pin level.
module tws_sync (
  input wire aclk,
  input wire aresetn,
  input wire d,
  output wire q
);
  reg s1_r;
  reg s2_r;

  // Only the second stage is ever read by other logic.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

/* src/tws_slave_tx.v */
`timescale 1ns/1ps
`include "tws_map.vh"
// Behaviour
// - Upper seven bits address; bit0 enables general call.
// - Read direction enters transmit; write direction is not answered and is ignored.
// - Own address plus read: ACK, done, A8.
// - Lost arbitration then addressed read: ACK, B0.
// - Ack enable chooses normal or last byte.
// - Byte sent and ACK received: done, B8.
// - Byte sent and NACK: C0, then unaddressed.
// - Last byte answered with ACK: C8, leave.
// - After last byte, ignore master; send ones.
// - Clearing done in C0/C8 returns to idle matching.
// - Ack enable zero blocks address reply, keeps monitoring.
// - Deep sleep still matches address and wakes part.
// - Hold SCL low after sleep match until done cleared.
// - Data register need not hold bus byte after wake.
// - Done flag clear reads status F8.
// - Misplaced start/stop: code 00; stop recovery releases lines.
module tws_slave_tx (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  input wire arb_lost,
  output wire irq,
  output wire wake
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WAIT = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_RACK = 3'd5;
  localparam ST_IGN = 3'd6;

  wire scl_s;
  wire sda_s;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [7:0] code_r;
  reg last_r;
  reg hold_r;
  reg sda_drv_r;
  reg [7:0] data_r;
  reg [7:0] sla_r;
  reg done_r;
  reg ack_en_r;
  reg sta_r;
  reg sto_r;
  reg wcol_r;
  reg en_r;
  reg sleep_r;
  reg ie_r;
  reg wake_r;
  reg aw_ok_r;
  reg w_ok_r;
  reg [3:0] awaddr_r;
  reg [7:0] wbyte_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [7:0] rd_nxt;
  reg rd_ok;

  tws_sync u_scl (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(scl_i),
    .q(scl_s)
  );
  tws_sync u_sda (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sda_i),
    .q(sda_s)
  );

  // Bus edges and conditions, found on the synchronised levels.
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire framed = (st_r != ST_IDLE) && (st_r != ST_IGN) && (st_r != ST_ADDR);
  wire adr_hit = (sh_r[7:1] == sla_r[7:1]) ||
                 (sla_r[0] && sh_r[7:1] == `TWS_GCALL);
  wire do_write = aw_ok_r & w_ok_r & ~bvalid_r;
  wire wr_ctrl = do_write && awaddr_r == `TWS_ADDR_CTRL;
  wire wr_data = do_write && awaddr_r == `TWS_ADDR_DATA;
  wire wr_sla = do_write && awaddr_r == `TWS_ADDR_SLA;
  // Writing one to the done bit clears it and releases the byte engine.
  wire release_go = wr_ctrl & wbyte_r[`TWS_C_DONE] & done_r;

  // Bus engine. Reading the master's clock only from aclk means a stretched
  // sleep wake-up is modelled by the sleep input rather than a stopped clock.
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      code_r <= `TWS_ST_NONE;
      last_r <= 1'b0;
      hold_r <= 1'b0;
      sda_drv_r <= 1'b0;
      done_r <= 1'b0;
      wake_r <= 1'b0;
      sto_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (wr_ctrl) begin
        sto_r <= wbyte_r[`TWS_C_STO];
      end
      if (release_go) begin
        done_r <= 1'b0;
        hold_r <= 1'b0;
        wake_r <= 1'b0;
        if (code_r == `TWS_ST_BUSERR && wbyte_r[`TWS_C_STO]) begin
          st_r <= ST_IDLE;
          sda_drv_r <= 1'b0;
          sto_r <= 1'b0;
        end else if (code_r == `TWS_ST_DNACK || code_r == `TWS_ST_LAST_ACK) begin
          st_r <= ST_IDLE;
        end else if (st_r == ST_WAIT) begin
          last_r <= ~wbyte_r[`TWS_C_ACK];
          st_r <= ST_TX;
          bit_r <= 4'h0;
        end
      end
      if (!en_r) begin
        st_r <= ST_IDLE;
        sda_drv_r <= 1'b0;
      end else if ((start_c || stop_c) && framed && !done_r) begin
        code_r <= `TWS_ST_BUSERR;
        done_r <= 1'b1;
        sda_drv_r <= 1'b0;
        st_r <= ST_IGN;
      end else if (start_c) begin
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
      end else if (stop_c && st_r != ST_WAIT) begin
        st_r <= ST_IDLE;
      end else begin
        case (st_r)
          ST_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8) begin
              if (ack_en_r && adr_hit && sh_r[0]) begin
                sda_drv_r <= 1'b1;
                st_r <= ST_AACK;
                wake_r <= sleep_r;
              end else begin
                st_r <= ST_IGN;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              sda_drv_r <= 1'b0;
              code_r <= arb_lost ? `TWS_ST_ARB_R : `TWS_ST_SLA_R;
              done_r <= 1'b1;
              hold_r <= sleep_r;
              st_r <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            sh_r <= data_r;
          end
          ST_TX: begin
            if (bit_r == 4'h0) begin
              sda_drv_r <= ~sh_r[7];
              bit_r <= 4'h1;
            end else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_drv_r <= 1'b0;
                st_r <= ST_RACK;
              end else begin
                sda_drv_r <= ~sh_r[6];
                sh_r <= {sh_r[6:0], 1'b1};
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Ack is taken on the rise; the flag waits for the fall so that the
            // stretch never cuts short the master's high phase.
            if (scl_rise) begin
              sh_r <= {7'h00, sda_s};
              bit_r <= 4'h9;
            end
            if (scl_fall && bit_r == 4'h9) begin
              done_r <= 1'b1;
              if (sh_r[0]) begin
                code_r <= `TWS_ST_DNACK;
                st_r <= ST_IGN;
              end else if (last_r) begin
                code_r <= `TWS_ST_LAST_ACK;
                st_r <= ST_IGN;
              end else begin
                code_r <= `TWS_ST_DACK;
                st_r <= ST_WAIT;
              end
            end
          end
          ST_IGN: begin
            sda_drv_r <= 1'b0;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register file. The data register keeps its own value across sleep.
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= 8'hff;
      sla_r <= 8'h00;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      wcol_r <= 1'b0;
      en_r <= 1'b0;
      sleep_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      if (wr_data) begin
        if (done_r) begin
          data_r <= wbyte_r;
        end else begin
          wcol_r <= 1'b1;
        end
      end
      if (wr_sla) begin
        sla_r <= wbyte_r;
      end
      if (wr_ctrl) begin
        ack_en_r <= wbyte_r[`TWS_C_ACK];
        sta_r <= wbyte_r[`TWS_C_STA];
        en_r <= wbyte_r[`TWS_C_EN];
        sleep_r <= wbyte_r[`TWS_C_SLEEP];
        ie_r <= wbyte_r[`TWS_C_IE];
        if (wbyte_r[`TWS_C_WCOL]) begin
          wcol_r <= 1'b0;
        end
      end
    end
  end

  // Read mux. Status shows F8 whenever no event is pending.
  always @* begin
    rd_nxt = 8'h00;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TWS_ADDR_CTRL: rd_nxt = {done_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, sleep_r, ie_r};
      `TWS_ADDR_STAT: rd_nxt = done_r ? code_r : `TWS_ST_NONE;
      `TWS_ADDR_DATA: rd_nxt = data_r;
      `TWS_ADDR_SLA: rd_nxt = sla_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI4-Lite slave: address and data latch separately, one answer each.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 4'h0;
      wbyte_r <= 8'h00;
      bvalid_r <= 1'b0;
      bresp_r <= `TWS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TWS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_ok_r) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok_r) begin
        w_ok_r <= 1'b1;
        wbyte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (do_write) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r == `TWS_ADDR_STAT) ? `TWS_RESP_SLVERR : `TWS_RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_nxt};
        rresp_r <= rd_ok ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_ok_r;
  assign s_axi_wready = ~w_ok_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // Open-drain pins: only ever pull low. SCL is stretched while a byte waits.
  assign sda_o = 1'b0;
  assign sda_oe = sda_drv_r;
  assign scl_o = 1'b0;
  assign scl_oe = hold_r | (done_r & (st_r == ST_WAIT));
  assign irq = done_r & ie_r;
  assign wake = wake_r;
endmodule

/* test/tws_chk.sv */
`timescale 1ns/1ps
// Pin and interrupt relations of the slave transmitter.
module tws_chk (
  input wire aclk,
  input wire aresetn,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe,
  input wire irq,
  input wire wake
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A wake-up starts when the sleeping unit hears its own address.
  sequence woke_s;
    $rose(wake);
  endsequence
  // The stretch must outlast the wake flag, or the master runs on.
  sequence held_s;
    wake && scl_oe;
  endsequence
  drv_zero_a: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  sda_edge_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data moved with clock high");
  scl_grab_a: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch began with clock high");
  irq_rise_a: assert property ($rose(irq) |-> !scl_i)
    else $error("done raised with clock high");
  irq_hold_a: assert property (irq && scl_oe |=> scl_oe || !irq)
    else $error("stretch dropped before done cleared");
  wake_str_a: assert property (woke_s |-> ##[0:40] scl_oe)
    else $error("no stretch after wake");
  wake_hold_a: assert property (held_s |=> scl_oe || !wake)
    else $error("stretch dropped during wake");
  wake_off_a: assert property ($fell(wake) |-> ##[0:1] !irq)
    else $error("wake ended with done pending");
endmodule
bind tws_slave_tx tws_chk u_chk (.aclk(aclk), .aresetn(aresetn), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq),
  .wake(wake));

/* test/tws_mst.sv */
`timescale 1ns/1ps
// Master receiver; it only pulls lines low and the pull-up does the rest.
module tws_mst (
  output logic scl_oe,
  output logic sda_oe,
  input wire scl,
  input wire sda
);
  logic stuck;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end
  // Release SCL and wait out a stretch; bounded so a stuck slave cannot hang us.
  task automatic hi;
    int n;
    scl_oe = 1'b0;
    n = 0;
    while (!scl && n < 4000) begin
      #5;
      n++;
    end
    if (n >= 4000) stuck = 1'b1;
    #30;
  endtask
  // Data moves halfway through the low phase, so the slave sees SCL fall first.
  task automatic bit_io(input logic b, output logic r);
    #70;
    sda_oe = !b;
    #70;
    hi();
    r = sda;
    #30;
    scl_oe = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
    output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, ao);
  endtask
  task automatic start;
    sda_oe = 1'b1;
    #70;
    scl_oe = 1'b1;
  endtask
  task automatic stop;
    #70;
    sda_oe = 1'b1;
    #70;
    hi();
    sda_oe = 1'b0;
    #100;
  endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "tws_map.vh"
// Registers over AXI4-Lite, the link through the master model.
module tb_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, arb = 0;
  logic [3:0] awa = 0, ara = 0;
  logic [7:0] wd = 0;
  wire awr, wr_r, bv, arr, rv, scl_oe, sda_oe, m_scl, m_sda, irq, wake;
  wire [1:0] br, rrs;
  wire [31:0] rdat;
  wire scl = !(m_scl | scl_oe);
  wire sda = !(m_sda | sda_oe);
  int checks = 0, n_mismatch = 0;
  always #12.5 aclk = ~aclk;
  tws_slave_tx dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .arb_lost(arb), .irq(irq),
    .wake(wake));
  tws_mst m (.scl_oe(m_scl), .sda_oe(m_sda), .scl(scl), .sda(sda));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tmo;
    chk("handshake", 8'h01, 8'h00);
    print_verdict();
  endtask
  // Each channel holds valid and payload until its ready is seen high at a rising edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    logic got;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    got = 0;
    n = 0;
    while (!got && n < 50) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      got = bv;
      r = br;
      n++;
    end
    if (!got) tmo();
    chk("bresp", {6'h0, er}, {6'h0, r});
    @(negedge aclk);
  endtask
  // Read data and response are taken at the edge where rvalid is seen high.
  task automatic rd(input logic [3:0] a, output logic [7:0] d, input logic [1:0] er = 2'b00);
    logic got;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    got = 0;
    n = 0;
    while (!got && n < 50) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      got = rv;
      d = rdat[7:0];
      r = rrs;
      n++;
    end
    if (!got) tmo();
    chk("rresp", {6'h0, er}, {6'h0, r});
    @(negedge aclk);
  endtask
  task automatic wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(negedge aclk);
      n++;
    end
    if (n >= 4000) tmo();
  endtask
  // An address the unit must not answer leaves the ninth bit released.
  task automatic nseq(input logic [7:0] ad, input logic [7:0] ctl);
    logic [7:0] q;
    logic a;
    wr(`TWS_ADDR_CTRL, ctl);
    m.start();
    m.xfer(ad, 1'b1, q, a);
    m.stop();
    chk("nack", 8'h01, {7'h0, a});
    chk("irq", 8'h00, {7'h0, irq});
  endtask
  // Address, one acknowledged byte, then a last byte answered by mack.
  task automatic rseq(input logic al, input logic slp, input logic mack);
    logic [7:0] q, v, e;
    logic a;
    @(posedge aclk);
    arb <= al;
    wr(`TWS_ADDR_CTRL, {6'h11, slp, 1'b1});
    m.start();
    m.xfer(8'h55, 1'b1, q, a);
    chk("ack", 8'h00, {7'h0, a});
    wirq();
    chk("wake", {7'h0, slp}, {7'h0, wake});
    chk("stretch", 8'h01, {7'h0, scl_oe});
    rd(`TWS_ADDR_STAT, v);
    e = al ? `TWS_ST_ARB_R : `TWS_ST_SLA_R;
    chk("entry", e, v & 8'hf8);
    wr(`TWS_ADDR_CTRL, 8'h44);
    chk("masked", 8'h00, {7'h0, irq});
    for (int i = 0; i < 2; i++) begin
      wr(`TWS_ADDR_DATA, 8'hc3 ^ i[7:0]);
      wr(`TWS_ADDR_CTRL, i ? 8'h85 : 8'hc5);
      chk("woken", 8'h00, {7'h0, wake});
      m.xfer(8'hff, i ? mack : 1'b0, q, a);
      chk("data", 8'hc3 ^ i[7:0], q);
      wirq();
      rd(`TWS_ADDR_STAT, v);
      e = mack ? `TWS_ST_DNACK : `TWS_ST_LAST_ACK;
      chk("byte", i ? e : `TWS_ST_DACK, v & 8'hf8);
    end
    wr(`TWS_ADDR_CTRL, 8'hc5);
    rd(`TWS_ADDR_STAT, v);
    chk("cleared", `TWS_ST_NONE, v);
    if (!mack) begin
      m.xfer(8'hff, 1'b1, q, a);
      chk("ones", 8'hff, q);
    end
    m.stop();
    chk("quiet", 8'h00, {7'h0, irq});
  endtask
  initial begin
    logic [7:0] v;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TWS_ADDR_STAT, v);
    chk("idle", `TWS_ST_NONE, v);
    rd(4'h2, v, `TWS_RESP_SLVERR);
    chk("unmapped", 8'h00, v);
    wr(`TWS_ADDR_DATA, 8'h12);
    rd(`TWS_ADDR_CTRL, v);
    chk("collision", 8'h08, v);
    wr(`TWS_ADDR_CTRL, 8'h08);
    rd(`TWS_ADDR_CTRL, v);
    chk("collision clear", 8'h00, v);
    wr(`TWS_ADDR_STAT, 8'h00, `TWS_RESP_SLVERR);
    wr(`TWS_ADDR_SLA, 8'h54);
    nseq(8'h01, 8'h45);
    wr(`TWS_ADDR_SLA, 8'h55);
    rd(`TWS_ADDR_SLA, v);
    chk("own", 8'h55, v);
    nseq(8'h57, 8'h45);
    nseq(8'h55, 8'h05);
    rseq(1'b0, 1'b0, 1'b1);
    rseq(1'b1, 1'b0, 1'b0);
    rseq(1'b0, 1'b1, 1'b1);
    chk("scl stuck", 8'h00, {7'h0, m.stuck});
    print_verdict();
  end
endmodule
